// file: logic/periph_irq_flags.sv
// Peripheral interrupt flag banks two and three with an AXI4-Lite register slave
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps

module periph_irq_flags (
   input  wire logic        mclk,
   input  wire logic        sys_rst,
   input  wire logic        oscFailEvent,
   input  wire logic        comparatorBEvent,
   input  wire logic        comparatorAEvent,
   input  wire logic        eepromWriteDoneEvent,
   input  wire logic        serialCollisionEvent,
   input  wire logic        lcdEvent,
   input  wire logic        capcompTwoEvent,
   input  wire logic        capcompThreeEvent,
   input  wire logic        capcompFourEvent,
   input  wire logic        capcompFiveEvent,
   input  wire logic        timerSixMatchEvent,
   input  wire logic        timerFourMatchEvent,
   input  wire logic        globalIrqEnable,
   input  wire logic        peripheralIrqEnable,
   output logic             irqRequest,
   output logic [7:0]       pendingTwo,
   output logic [7:0]       pendingThree,
   input  wire logic [3:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [3:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready
);

   // Register state
   periph_irq_pkg::state_t state_reg;
   periph_irq_pkg::state_t state_next;

   // Event vectors in register bit order
   logic [7:0]             eventTwo;
   logic [7:0]             eventThree;

   // Write channel
   logic                   awTake;
   logic                   wTake;
   logic                   doWrite;
   logic                   bDone;
   logic                   wLaneOn;
   logic [7:0]             wByte;

   // Write decode
   logic                   wSelFlagsTwo;
   logic                   wSelFlagsThree;
   logic                   wSelEnableTwo;
   logic                   wSelEnableThree;
   logic                   wSelNone;
   logic                   flagsTwoWr;
   logic                   flagsThreeWr;
   logic                   enableTwoWr;
   logic                   enableThreeWr;
   logic [1:0]             writeResp;

   // Read channel
   logic                   doRead;
   logic                   rDone;
   logic                   rSelFlagsTwo;
   logic                   rSelFlagsThree;
   logic                   rSelEnableTwo;
   logic                   rSelEnableThree;
   logic                   rSelNone;
   logic [7:0]             readByte;
   logic [31:0]            readWord;
   logic [1:0]             readResp;

   // Bank next values
   wire logic [7:0]        flagsTwoNext;
   wire logic [7:0]        flagsThreeNext;
   wire logic [7:0]        enableTwoNext;
   wire logic [7:0]        enableThreeNext;

   // Request
   wire logic [7:0]        armedTwo;
   wire logic [7:0]        armedThree;
   logic                   anyArmed;
   logic                   gateOpen;

   // ------------------------------------------------------------
   // Event bit placement
   // ------------------------------------------------------------
   always_comb begin
      eventTwo = periph_irq_pkg::RESET_BYTE;
      eventTwo[periph_irq_pkg::BIT_OSC_FAIL]    = oscFailEvent;
      eventTwo[periph_irq_pkg::BIT_COMP_B]      = comparatorBEvent;
      eventTwo[periph_irq_pkg::BIT_COMP_A]      = comparatorAEvent;
      eventTwo[periph_irq_pkg::BIT_EEPROM_DONE] = eepromWriteDoneEvent;
      eventTwo[periph_irq_pkg::BIT_SER_COLL]    = serialCollisionEvent;
      eventTwo[periph_irq_pkg::BIT_LCD]         = lcdEvent;
      eventTwo[periph_irq_pkg::BIT_CAPCOMP_TWO] = capcompTwoEvent;
      eventThree = periph_irq_pkg::RESET_BYTE;
      eventThree[periph_irq_pkg::BIT_CAPCOMP_5]  = capcompFiveEvent;
      eventThree[periph_irq_pkg::BIT_CAPCOMP_4]  = capcompFourEvent;
      eventThree[periph_irq_pkg::BIT_CAPCOMP_3]  = capcompThreeEvent;
      eventThree[periph_irq_pkg::BIT_TIMER_SIX]  = timerSixMatchEvent;
      eventThree[periph_irq_pkg::BIT_TIMER_FOUR] = timerFourMatchEvent;
   end

   // ------------------------------------------------------------
   // Write channel handshake
   // ------------------------------------------------------------
   always_comb begin
      awTake  = s_axi_awvalid && !state_reg.awHeld;
      wTake   = s_axi_wvalid && !state_reg.wHeld;
      doWrite = state_reg.awHeld && state_reg.wHeld && !state_reg.bValid;
      bDone   = state_reg.bValid && s_axi_bready;
   end

   // ------------------------------------------------------------
   // Write data lane
   // ------------------------------------------------------------
   // Only byte lane 0 carries register bits
   always_comb begin
      wLaneOn = state_reg.wStrb[0];
      wByte   = state_reg.wData[7:0];
   end

   // ------------------------------------------------------------
   // Write address decode
   // ------------------------------------------------------------
   always_comb begin
      wSelFlagsTwo    = 1'b0;
      wSelFlagsThree  = 1'b0;
      wSelEnableTwo   = 1'b0;
      wSelEnableThree = 1'b0;
      wSelNone        = 1'b0;
      if (state_reg.awAddr == periph_irq_pkg::ADDR_FLAGS_TWO) begin
         wSelFlagsTwo = 1'b1;
      end else if (state_reg.awAddr == periph_irq_pkg::ADDR_FLAGS_THREE) begin
         wSelFlagsThree = 1'b1;
      end else if (state_reg.awAddr == periph_irq_pkg::ADDR_ENABLE_TWO) begin
         wSelEnableTwo = 1'b1;
      end else if (state_reg.awAddr == periph_irq_pkg::ADDR_ENABLE_THREE) begin
         wSelEnableThree = 1'b1;
      end else begin
         wSelNone = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Write strobes
   // ------------------------------------------------------------
   always_comb begin
      flagsTwoWr    = doWrite && wLaneOn && wSelFlagsTwo;
      flagsThreeWr  = doWrite && wLaneOn && wSelFlagsThree;
      enableTwoWr   = doWrite && wLaneOn && wSelEnableTwo;
      enableThreeWr = doWrite && wLaneOn && wSelEnableThree;
   end

   // ------------------------------------------------------------
   // Write response
   // ------------------------------------------------------------
   // A write with byte lane 0 off is dropped but still answered OKAY
   always_comb begin
      writeResp = periph_irq_pkg::RESP_OKAY;
      if (wLaneOn && wSelNone) begin
         writeResp = periph_irq_pkg::RESP_SLVERR;
      end
   end

   // ------------------------------------------------------------
   // Flag bits, bank two
   // ------------------------------------------------------------
   // Events win over a software write in the same cycle
   for (genvar i = 0; i < $bits(eventTwo); i++) begin : g_flagTwo
      assign flagsTwoNext[i] = periph_irq_pkg::MASK_TWO[i]
                               && (eventTwo[i] || (flagsTwoWr ? wByte[i] : state_reg.flags.two[i]));
   end

   // ------------------------------------------------------------
   // Flag bits, bank three
   // ------------------------------------------------------------
   for (genvar i = 0; i < $bits(eventThree); i++) begin : g_flagThree
      assign flagsThreeNext[i] = periph_irq_pkg::MASK_THREE[i]
                                 && (eventThree[i] || (flagsThreeWr ? wByte[i] : state_reg.flags.three[i]));
   end

   // ------------------------------------------------------------
   // Enable bits, bank two
   // ------------------------------------------------------------
   for (genvar i = 0; i < $bits(eventTwo); i++) begin : g_enableTwo
      assign enableTwoNext[i] = periph_irq_pkg::MASK_TWO[i]
                                && (enableTwoWr ? wByte[i] : state_reg.enables.two[i]);
   end

   // ------------------------------------------------------------
   // Enable bits, bank three
   // ------------------------------------------------------------
   for (genvar i = 0; i < $bits(eventThree); i++) begin : g_enableThree
      assign enableThreeNext[i] = periph_irq_pkg::MASK_THREE[i]
                                  && (enableThreeWr ? wByte[i] : state_reg.enables.three[i]);
   end

   // ------------------------------------------------------------
   // Read channel handshake
   // ------------------------------------------------------------
   always_comb begin
      doRead = s_axi_arvalid && !state_reg.rValid;
      rDone  = state_reg.rValid && s_axi_rready;
   end

   // ------------------------------------------------------------
   // Read address decode
   // ------------------------------------------------------------
   always_comb begin
      rSelFlagsTwo    = 1'b0;
      rSelFlagsThree  = 1'b0;
      rSelEnableTwo   = 1'b0;
      rSelEnableThree = 1'b0;
      rSelNone        = 1'b0;
      if (s_axi_araddr == periph_irq_pkg::ADDR_FLAGS_TWO) begin
         rSelFlagsTwo = 1'b1;
      end else if (s_axi_araddr == periph_irq_pkg::ADDR_FLAGS_THREE) begin
         rSelFlagsThree = 1'b1;
      end else if (s_axi_araddr == periph_irq_pkg::ADDR_ENABLE_TWO) begin
         rSelEnableTwo = 1'b1;
      end else if (s_axi_araddr == periph_irq_pkg::ADDR_ENABLE_THREE) begin
         rSelEnableThree = 1'b1;
      end else begin
         rSelNone = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // Read data
   // ------------------------------------------------------------
   always_comb begin
      readByte = periph_irq_pkg::RESET_BYTE;
      if (rSelFlagsTwo) begin
         readByte = state_reg.flags.two;
      end else if (rSelFlagsThree) begin
         readByte = state_reg.flags.three;
      end else if (rSelEnableTwo) begin
         readByte = state_reg.enables.two;
      end else if (rSelEnableThree) begin
         readByte = state_reg.enables.three;
      end
      readWord      = periph_irq_pkg::WORD_ZERO;
      readWord[7:0] = readByte;
   end

   // ------------------------------------------------------------
   // Read response
   // ------------------------------------------------------------
   // Unmapped reads return zero with an error response
   always_comb begin
      readResp = periph_irq_pkg::RESP_OKAY;
      if (rSelNone) begin
         readResp = periph_irq_pkg::RESP_SLVERR;
      end
   end

   // ------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------
   always_comb begin
      state_next               = state_reg;
      state_next.flags.two     = flagsTwoNext;
      state_next.flags.three   = flagsThreeNext;
      state_next.enables.two   = enableTwoNext;
      state_next.enables.three = enableThreeNext;

      // Address and data may arrive in either order
      if (awTake) begin
         state_next.awHeld = 1'b1;
         state_next.awAddr = s_axi_awaddr;
      end
      if (wTake) begin
         state_next.wHeld = 1'b1;
         state_next.wData = s_axi_wdata;
         state_next.wStrb = s_axi_wstrb;
      end

      if (doWrite) begin
         state_next.awHeld = 1'b0;
         state_next.wHeld  = 1'b0;
         state_next.bValid = 1'b1;
         state_next.bResp  = writeResp;
      end else if (bDone) begin
         state_next.bValid = 1'b0;
      end

      if (doRead) begin
         state_next.rValid = 1'b1;
         state_next.rResp  = readResp;
         state_next.rData  = readWord;
      end else if (rDone) begin
         state_next.rValid = 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Armed sources
   // ------------------------------------------------------------
   for (genvar i = 0; i < $bits(eventTwo); i++) begin : g_armed
      assign armedTwo[i]   = state_reg.flags.two[i] && state_reg.enables.two[i];
      assign armedThree[i] = state_reg.flags.three[i] && state_reg.enables.three[i];
   end

   // ------------------------------------------------------------
   // Request gate
   // ------------------------------------------------------------
   always_comb begin
      anyArmed = (|armedTwo) || (|armedThree);
      gateOpen = globalIrqEnable && peripheralIrqEnable;
   end

   // ------------------------------------------------------------
   // State register
   // ------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign s_axi_awready = !state_reg.awHeld;
   assign s_axi_wready  = !state_reg.wHeld;
   assign s_axi_bvalid  = state_reg.bValid;
   assign s_axi_bresp   = state_reg.bResp;

   // ------------------------------------------------------------
   // Read channel outputs
   // ------------------------------------------------------------
   assign s_axi_arready = !state_reg.rValid;
   assign s_axi_rvalid  = state_reg.rValid;
   assign s_axi_rdata   = state_reg.rData;
   assign s_axi_rresp   = state_reg.rResp;

   // ------------------------------------------------------------
   // Flag and request outputs
   // ------------------------------------------------------------
   assign pendingTwo    = state_reg.flags.two;
   assign pendingThree  = state_reg.flags.three;
   assign irqRequest    = gateOpen && anyArmed;

endmodule

// file: logic/periph_irq_pkg.sv
// Package: register map, bit layouts and bus types of the peripheral interrupt flag block
package periph_irq_pkg;

   // ------------------------------------------------------------
   // Register byte addresses
   // ------------------------------------------------------------
   localparam logic [3:0] ADDR_FLAGS_TWO    = 4'h0;
   localparam logic [3:0] ADDR_FLAGS_THREE  = 4'h4;
   localparam logic [3:0] ADDR_ENABLE_TWO   = 4'h8;
   localparam logic [3:0] ADDR_ENABLE_THREE = 4'hC;
   localparam int         ADDR_W            = 4;

   // ------------------------------------------------------------
   // Bit layouts
   // ------------------------------------------------------------
   localparam logic [7:0] MASK_TWO   = 8'hFD;
   localparam logic [7:0] MASK_THREE = 8'h7A;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam int BIT_OSC_FAIL    = 7;
   localparam int BIT_COMP_B      = 6;
   localparam int BIT_COMP_A      = 5;
   localparam int BIT_EEPROM_DONE = 4;
   localparam int BIT_SER_COLL    = 3;
   localparam int BIT_LCD         = 2;
   localparam int BIT_CAPCOMP_TWO = 0;
   localparam int BIT_CAPCOMP_5   = 6;
   localparam int BIT_CAPCOMP_4   = 5;
   localparam int BIT_CAPCOMP_3   = 4;
   localparam int BIT_TIMER_SIX   = 3;
   localparam int BIT_TIMER_FOUR  = 1;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [31:0] WORD_ZERO  = 32'h00000000;

   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] two;
      logic [7:0] three;
   } bank_t;

   typedef struct packed {
      bank_t       flags;
      bank_t       enables;
      logic        awHeld;
      logic [3:0]  awAddr;
      logic        wHeld;
      logic [31:0] wData;
      logic [3:0]  wStrb;
      logic        bValid;
      logic [1:0]  bResp;
      logic        rValid;
      logic [31:0] rData;
      logic [1:0]  rResp;
   } state_t;

endpackage

// file: tb/periph_irq_flags_checker.sv
// Checker for the flag banks, the request output and the reset state
`timescale 1ns/1ps
module periph_irq_flags_checker (
   input wire logic       mclk, sys_rst, globalIrqEnable, peripheralIrqEnable, irqRequest, s_axi_bvalid,
   input wire logic       oscFailEvent, comparatorBEvent, comparatorAEvent, eepromWriteDoneEvent,
   input wire logic       serialCollisionEvent, lcdEvent, capcompTwoEvent, capcompThreeEvent,
   input wire logic       capcompFourEvent, capcompFiveEvent, timerSixMatchEvent, timerFourMatchEvent,
   input wire logic [7:0] pendingTwo, pendingThree
);
   wire logic [7:0] evTwo = {oscFailEvent, comparatorBEvent, comparatorAEvent, eepromWriteDoneEvent,
                             serialCollisionEvent, lcdEvent, 1'b0, capcompTwoEvent};
   wire logic [7:0] evThree = {1'b0, capcompFiveEvent, capcompFourEvent, capcompThreeEvent,
                               timerSixMatchEvent, 1'b0, timerFourMatchEvent, 1'b0};
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);
   property p_setTwo; 1 |=> (pendingTwo & $past(evTwo)) == $past(evTwo); endproperty
   a_setTwo: assert property (p_setTwo) else $error("bank two flag missed its event");
   property p_setThree; 1 |=> (pendingThree & $past(evThree)) == $past(evThree); endproperty
   a_setThree: assert property (p_setThree) else $error("bank three flag missed its event");
   // Flags change only by an event or at the edge a write completes
   property p_sticky;
      1 |=> $rose(s_axi_bvalid) || {pendingTwo, pendingThree} == ($past({pendingTwo, pendingThree}) | $past({evTwo, evThree}));
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag changed without cause");
   property p_holeTwo; pendingTwo[1] == 1'b0; endproperty
   a_holeTwo: assert property (p_holeTwo) else $error("bank two bit 1 set");
   property p_holeThree; (pendingThree & 8'h85) == 8'h00; endproperty
   a_holeThree: assert property (p_holeThree) else $error("bank three empty bit set");
   property p_reset; disable iff (1'b0) sys_rst |=> {pendingTwo, pendingThree} == 16'h0000 && !irqRequest; endproperty
   a_reset: assert property (p_reset) else $error("flags not cleared by reset");
   property p_irqFlag; irqRequest |-> (pendingTwo | pendingThree) != 8'h00; endproperty
   a_irqFlag: assert property (p_irqFlag) else $error("request without a flag");
   property p_irqGate; irqRequest |-> globalIrqEnable && peripheralIrqEnable; endproperty
   a_irqGate: assert property (p_irqGate) else $error("request while gated off");
   c_irq: cover property (irqRequest);
   c_write: cover property ($rose(s_axi_bvalid));
   c_clear: cover property ($fell(pendingTwo[7]));
endmodule

bind periph_irq_flags periph_irq_flags_checker i_chk (.*);

// file: tb/event_source_model.sv
// Peripheral event sources: a one-cycle request becomes a one-cycle event pulse
`timescale 1ns/1ps
module event_source_model (
   input  wire logic                  mclk,
   input  wire periph_irq_pkg::bank_t fireReq,
   output periph_irq_pkg::bank_t      events
);
   always_ff @(posedge mclk) begin
      events <= fireReq;
   end
endmodule

// file: tb/periph_irq_flags_tb.sv
// Self-checking bench for the peripheral interrupt flag block
`timescale 1ns/1ps
module periph_irq_flags_tb;
   logic mclk = 1'b0, sys_rst = 1'b1, gEn = 1'b0, pEn = 1'b0, awValid = 1'b0, wValid = 1'b0;
   logic bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
   logic [3:0] awAddr = 4'h0, arAddr = 4'h0;
   logic [31:0] wData = 32'h0, rnd = 32'hB97A, rd;
   logic [1:0] rsp;
   periph_irq_pkg::bank_t fire = '0, ev, expF, expE;
   wire logic awRdy, wRdy, arRdy, bValid, rValid, irq;
   wire logic [1:0] bResp, rResp;
   wire logic [31:0] rData;
   wire logic [7:0] pTwo, pThree;
   wire logic [15:0] allMask = {periph_irq_pkg::MASK_TWO, periph_irq_pkg::MASK_THREE};
   int errCount = 0, checksDone = 0;
   always #4 mclk = ~mclk;
   event_source_model i_src (.mclk(mclk), .fireReq(fire), .events(ev));
   periph_irq_flags i_dut (.mclk(mclk), .sys_rst(sys_rst), .oscFailEvent(ev.two[7]), .comparatorBEvent(ev.two[6]),
      .comparatorAEvent(ev.two[5]), .eepromWriteDoneEvent(ev.two[4]), .serialCollisionEvent(ev.two[3]),
      .lcdEvent(ev.two[2]), .capcompTwoEvent(ev.two[0]), .capcompThreeEvent(ev.three[4]),
      .capcompFourEvent(ev.three[5]), .capcompFiveEvent(ev.three[6]), .timerSixMatchEvent(ev.three[3]),
      .timerFourMatchEvent(ev.three[1]), .globalIrqEnable(gEn), .peripheralIrqEnable(pEn), .irqRequest(irq),
      .pendingTwo(pTwo), .pendingThree(pThree), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
      .s_axi_awready(awRdy), .s_axi_wdata(wData), .s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wRdy),
      .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
      .s_axi_arvalid(arValid), .s_axi_arready(arRdy), .s_axi_rdata(rData), .s_axi_rresp(rResp),
      .s_axi_rvalid(rValid), .s_axi_rready(rReady));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checksDone++;
      if (got !== exp) begin
         errCount++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic axw(input logic [3:0] a, input logic [7:0] d);
      @(posedge mclk);
      awAddr <= a;
      wData <= {24'h0, d};
      {awValid, wValid, bReady} <= 3'h7;
      while (awValid || wValid) begin
         @(posedge mclk);
         if (awRdy) awValid <= 1'b0;
         if (wRdy) wValid <= 1'b0;
      end
      do @(posedge mclk); while (!bValid);
      bReady <= 1'b0;
      chk(32'(bResp), 32'(periph_irq_pkg::RESP_OKAY));
   endtask
   task automatic axr(input logic [3:0] a);
      @(posedge mclk);
      arAddr <= a;
      {arValid, rReady} <= 2'h3;
      do @(posedge mclk); while (!arRdy);
      arValid <= 1'b0;
      do @(posedge mclk); while (!rValid);
      rReady <= 1'b0;
      rd = rData;
      rsp = rResp;
   endtask
   task automatic pulse(input periph_irq_pkg::bank_t m, input logic g, input logic p);
      @(posedge mclk);
      fire <= m;
      gEn <= g;
      pEn <= p;
      @(posedge mclk);
      fire <= '0;
      @(posedge mclk);
      #1;
   endtask
   task automatic testDone;
      $display("checks %0d errors %0d", checksDone, errCount);
      if (errCount == 0 && checksDone > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge mclk);
      errCount++;
      testDone;
   end
   initial begin
      repeat (8) @(posedge mclk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 4; i++) begin
         axr(4'(i * 4));
         chk(rd, 32'h0);
         chk(32'(rsp), 32'(periph_irq_pkg::RESP_OKAY));
         rnd = lfsr(rnd);
         axw(4'(i * 4), rnd[7:0]);
         axr(4'(i * 4));
         chk(rd, {24'h0, rnd[7:0] & allMask[(i % 2 == 0) * 8 +: 8]});
      end
      axr(4'h2);
      chk(32'(rsp), 32'(periph_irq_pkg::RESP_SLVERR));
      for (int i = 0; i < 4; i++) axw(4'(i * 4), 8'h00);
      // Each event alone, all enables off, then software clear
      for (int b = 0; b < 16; b++) begin
         pulse(16'(1 << b), 1'b0, 1'b0);
         chk(32'({pTwo, pThree}), 32'(16'(1 << b) & allMask));
         axr(b < 8 ? 4'h4 : 4'h0);
         chk(rd, 32'((16'(1 << b) & allMask) >> (b < 8 ? 0 : 8)));
         axw(b < 8 ? 4'h4 : 4'h0, 8'h00);
         chk(32'({pTwo, pThree}), 32'h0);
      end
      rnd = lfsr(rnd);
      expE = rnd[15:0] & allMask;
      axw(4'h8, expE.two);
      axw(4'hC, expE.three);
      expF = '0;
      for (int k = 0; k < 48; k++) begin
         rnd = lfsr(rnd);
         pulse(rnd[15:0] & rnd[31:16], rnd[20], rnd[9]);
         expF = expF | (rnd[15:0] & rnd[31:16] & allMask);
         chk(32'({pTwo, pThree}), 32'(expF));
         chk(32'(irq), 32'(gEn & pEn & (|(expF & expE))));
         if (k % 6 == 5) begin
            axw(4'h0, 8'h00);
            axw(4'h4, 8'h00);
            expF = '0;
         end
      end
      testDone;
   end
endmodule
